// ---- rtl/pdc_pkg.sv ----
package pdc_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CLKDIV = 8'h00;
  localparam logic [7:0] OFS_MULT   = 8'h04;
  localparam logic [7:0] OFS_MODE   = 8'h08;
  localparam logic [7:0] OFS_FIN    = 8'h0C;
  localparam logic [7:0] OFS_STAT   = 8'h10;
  localparam logic [7:0] OFS_VCO    = 8'h14;
  localparam logic [7:0] OFS_PLLO   = 8'h18;
  localparam logic [7:0] OFS_FOSC   = 8'h1C;
  localparam logic [7:0] OFS_FCY    = 8'h20;

  // ==========================================================
  // Field positions and widths
  localparam int DOZE_LSB   = 0;
  localparam int DOZE_W     = 3;
  localparam int DOZE_ENABLE_BIT_BIT  = 3;
  localparam int ROI_BIT    = 4;
  localparam int PRE_LSB    = 8;
  localparam int PRE_W      = 5;
  localparam int POST_LSB   = 16;
  localparam int POST_W     = 2;
  localparam int MULT_LSB   = 0;
  localparam int MULT_W     = 9;
  localparam int MODE_LSB   = 0;
  localparam int MODE_W     = 3;
  localparam int PLLSEL_BIT = 3;
  localparam int BUSY_BIT   = 0;
  localparam int PEND_BIT   = 1;

  // ==========================================================
  // Ratio arithmetic
  localparam int PRE_ADD   = 2;
  localparam int POST_ADD  = 1;
  localparam int POST_MUL  = 2;
  localparam int MULT_ADD  = 2;
  localparam int FCY_SHIFT = 1;

  // Clock modes that can route the PLL output
  localparam logic [2:0] MODE_PLL_A = 3'h1;
  localparam logic [2:0] MODE_PLL_B = 3'h3;

  // ==========================================================
  // Values after reset
  localparam logic [2:0]  RST_DOZE = 3'h0;
  localparam logic [4:0]  RST_PRE  = 5'h00;
  localparam logic [1:0]  RST_POST = 2'h0;
  localparam logic [8:0]  RST_MULT = 9'h000;
  localparam logic [2:0]  RST_MODE = 3'h0;
  localparam logic [31:0] RST_FIN  = 32'h00000000;

  typedef enum logic [1:0] {
    PDC_IDLE,
    PDC_VCO,
    PDC_OUT
  } pdc_state_t;

endpackage : pdc_pkg

// ---- rtl/pdc_div_if.sv ----
interface pdc_div_if #(
  parameter int DW  = 42,
  parameter int DVW = 9
);
  logic           start;
  logic [DW-1:0]  dividend;
  logic [DVW-1:0] divisor;
  logic           done;
  logic [DW-1:0]  quotient;

  modport req (output start, output dividend, output divisor,
               input done, input quotient);
  modport srv (input start, input dividend, input divisor,
               output done, output quotient);
endinterface : pdc_div_if

// ---- rtl/pdc_divider.sv ----
module pdc_divider #(
  parameter int DW  = 42,
  parameter int DVW = 9
) (
  input wire logic pclk,
  input wire logic presetn,
  pdc_div_if.srv   div
);

  localparam int CW       = $clog2(DW + 1);
  // Start edge, DW busy edges, then done_q is seen one edge later
  localparam int DONE_LAT = DW + 1;

  logic [DVW-1:0] rem_q;
  logic [DVW-1:0] dsr_q;
  logic [DW-1:0]  quo_q;
  logic [CW-1:0]  cnt_q;
  logic           busy_q;
  logic           done_q;
  logic [DVW:0]   shifted;
  logic [DVW+1:0] diff;

  // ==========================================================
  // Restoring divide, one quotient bit per clock
  assign shifted = {rem_q, quo_q[DW-1]};
  assign diff    = {1'b0, shifted} - {2'b0, dsr_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem_q  <= '0;
      dsr_q  <= '0;
      quo_q  <= '0;
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (div.start) begin
        // Operands latched so later register writes cannot skew it
        rem_q  <= '0;
        dsr_q  <= div.divisor;
        quo_q  <= div.dividend;
        cnt_q  <= CW'(DW);
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (!diff[DVW+1]) begin
          rem_q <= diff[DVW-1:0];
        end else begin
          rem_q <= shifted[DVW-1:0];
        end
        quo_q <= {quo_q[DW-2:0], ~diff[DVW+1]};
        cnt_q <= cnt_q - CW'(1);
        if (cnt_q == CW'(1)) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  assign div.done     = done_q;
  assign div.quotient = quo_q;

  // ==========================================================
  // Checks
  property p_div_latency;
    @(posedge pclk) disable iff (!presetn)
      div.start |-> ##DONE_LAT done_q;
  endproperty
  a_div_latency: assert property (p_div_latency)
    else $error("divider result not ready on time");

endmodule : pdc_divider

// ---- rtl/pdc_top.sv ----
// Contract
// - Instruction frequency is half the oscillator frequency.
// - PLL modes with PLL selected use PLL output.
// - PLL output is input times M over N1*N2.
// - N1=pre+2, N2=2*(post+1), M=mult+2.
// - VCO is input times M over N1.
// - Doze ratio writes ignored while doze enabled.
// - Doze enable cannot set with ratio zero.
// - Interrupt with recover bit clears doze enable.
//
// Our own choices: the APB slave port and the address map.
module pdc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        irq_async,
  output logic      [2:0]  doze_ratio_field,
  output logic             doze_active,
  output logic      [31:0] pll_output_freq,
  output logic      [31:0] sys_osc_freq,
  output logic      [31:0] instruction_cycle_freq
);

  localparam int PROD_W = 32 + pdc_pkg::MULT_W + 1;
  localparam int DVS_W  = 9;
  localparam int CHK_W  = PROD_W + DVS_W;

  // ==========================================================
  // Storage
  logic [2:0]  doze_q;
  logic [2:0]  doze_d;
  logic        doze_enable_bit_q;
  logic        doze_enable_bit_d;
  logic        roi_q;
  logic [4:0]  pre_q;
  logic [1:0]  post_q;
  logic [8:0]  mult_q;
  logic [2:0]  mode_q;
  logic        pllsel_q;
  logic [31:0] fin_q;
  logic [31:0] vco_q;
  logic [31:0] pllo_q;
  logic [31:0] fosc_q;
  logic [31:0] fosc_d;
  logic [31:0] fcy_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        pend_q;
  logic        irq_s1_q;
  logic        irq_s2_q;
  logic        irq_s3_q;
  logic        irq_lvl_q;
  logic        irq_evt;
  logic        acc;
  logic        wr;
  logic        cfg_wr;
  logic        pll_mode;
  logic [5:0]  prescale_ratio;
  logic [3:0]  postscale_ratio;
  logic [9:0]  feedback_mult;
  logic [8:0]  n1n2;
  logic [PROD_W-1:0] prod;

  pdc_pkg::pdc_state_t st_q;

  pdc_div_if #(.DW(PROD_W), .DVW(DVS_W)) div ();

  pdc_divider #(.DW(PROD_W), .DVW(DVS_W)) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .div     (div)
  );

  // ==========================================================
  // Decode helpers
  function automatic logic addr_hit(input logic [7:0] a);
    unique case (a)
      pdc_pkg::OFS_CLKDIV, pdc_pkg::OFS_MULT, pdc_pkg::OFS_MODE,
      pdc_pkg::OFS_FIN, pdc_pkg::OFS_STAT, pdc_pkg::OFS_VCO,
      pdc_pkg::OFS_PLLO, pdc_pkg::OFS_FOSC,
      pdc_pkg::OFS_FCY: addr_hit = 1'b1;
      default:          addr_hit = 1'b0;
    endcase
  endfunction : addr_hit

  function automatic logic [31:0] sat32(input logic [PROD_W-1:0] q);
    // Out-of-range settings pin the result rather than wrap
    if (|q[PROD_W-1:32]) begin
      sat32 = 32'hFFFFFFFF;
    end else begin
      sat32 = q[31:0];
    end
  endfunction : sat32

  // ==========================================================
  // Ratios
  assign prescale_ratio  = 6'(pre_q) + 6'(pdc_pkg::PRE_ADD);
  assign postscale_ratio = 4'(pdc_pkg::POST_MUL)
                         * (4'(post_q) + 4'(pdc_pkg::POST_ADD));
  assign feedback_mult   = 10'(mult_q) + 10'(pdc_pkg::MULT_ADD);
  assign n1n2            = 9'(prescale_ratio) * 9'(postscale_ratio);
  assign prod            = PROD_W'(fin_q) * PROD_W'(feedback_mult);

  // ==========================================================
  // APB slave, one wait state on every access
  assign acc    = psel & penable & pready_q;
  assign wr     = acc & pwrite;
  assign cfg_wr = wr & ((paddr == pdc_pkg::OFS_CLKDIV)
                      | (paddr == pdc_pkg::OFS_MULT)
                      | (paddr == pdc_pkg::OFS_FIN));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
      if (psel & penable & ~pready_q) begin
        pslverr_q <= ~addr_hit(paddr);
        if (!pwrite) begin
          unique case (paddr)
            pdc_pkg::OFS_CLKDIV: begin
              prdata_q[pdc_pkg::DOZE_LSB +: pdc_pkg::DOZE_W] <= doze_q;
              prdata_q[pdc_pkg::DOZE_ENABLE_BIT_BIT] <= doze_enable_bit_q;
              prdata_q[pdc_pkg::ROI_BIT] <= roi_q;
              prdata_q[pdc_pkg::PRE_LSB +: pdc_pkg::PRE_W] <= pre_q;
              prdata_q[pdc_pkg::POST_LSB +: pdc_pkg::POST_W] <= post_q;
            end
            pdc_pkg::OFS_MULT:
              prdata_q[pdc_pkg::MULT_LSB +: pdc_pkg::MULT_W] <= mult_q;
            pdc_pkg::OFS_MODE: begin
              prdata_q[pdc_pkg::MODE_LSB +: pdc_pkg::MODE_W] <= mode_q;
              prdata_q[pdc_pkg::PLLSEL_BIT] <= pllsel_q;
            end
            pdc_pkg::OFS_FIN:  prdata_q <= fin_q;
            pdc_pkg::OFS_STAT: begin
              prdata_q[pdc_pkg::BUSY_BIT] <= (st_q != pdc_pkg::PDC_IDLE);
              prdata_q[pdc_pkg::PEND_BIT] <= pend_q;
            end
            pdc_pkg::OFS_VCO:  prdata_q <= vco_q;
            pdc_pkg::OFS_PLLO: prdata_q <= pllo_q;
            pdc_pkg::OFS_FOSC: prdata_q <= fosc_q;
            pdc_pkg::OFS_FCY:  prdata_q <= fcy_q;
            default:           prdata_q <= 32'h00000000;
          endcase
        end
      end
    end
  end

  // ==========================================================
  // Interrupt input synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_s1_q  <= 1'b0;
      irq_s2_q  <= 1'b0;
      irq_s3_q  <= 1'b0;
      irq_lvl_q <= 1'b0;
    end else begin
      irq_s1_q <= irq_async;
      irq_s2_q <= irq_s1_q;
      irq_s3_q <= irq_s2_q;
      if (irq_s2_q == irq_s3_q) begin
        irq_lvl_q <= irq_s3_q;
      end
    end
  end

  assign irq_evt = irq_s2_q & irq_s3_q & ~irq_lvl_q;

  // ==========================================================
  // Doze control
  always_comb begin
    doze_d  = doze_q;
    doze_enable_bit_d = doze_enable_bit_q;
    if (wr && paddr == pdc_pkg::OFS_CLKDIV) begin
      if (!doze_enable_bit_q) begin
        doze_d = pwdata[pdc_pkg::DOZE_LSB +: pdc_pkg::DOZE_W];
      end
      doze_enable_bit_d = pwdata[pdc_pkg::DOZE_ENABLE_BIT_BIT]
              & (doze_d != 3'h0);
    end
    // Wake-up beats a software set landing in the same cycle
    if (roi_q && irq_evt) begin
      doze_enable_bit_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      doze_q  <= pdc_pkg::RST_DOZE;
      doze_enable_bit_q <= 1'b0;
    end else begin
      doze_q  <= doze_d;
      doze_enable_bit_q <= doze_enable_bit_d;
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      roi_q    <= 1'b0;
      pre_q    <= pdc_pkg::RST_PRE;
      post_q   <= pdc_pkg::RST_POST;
      mult_q   <= pdc_pkg::RST_MULT;
      mode_q   <= pdc_pkg::RST_MODE;
      pllsel_q <= 1'b0;
      fin_q    <= pdc_pkg::RST_FIN;
    end else if (wr) begin
      unique case (paddr)
        pdc_pkg::OFS_CLKDIV: begin
          roi_q  <= pwdata[pdc_pkg::ROI_BIT];
          pre_q  <= pwdata[pdc_pkg::PRE_LSB +: pdc_pkg::PRE_W];
          post_q <= pwdata[pdc_pkg::POST_LSB +: pdc_pkg::POST_W];
        end
        pdc_pkg::OFS_MULT:
          mult_q <= pwdata[pdc_pkg::MULT_LSB +: pdc_pkg::MULT_W];
        pdc_pkg::OFS_MODE: begin
          mode_q   <= pwdata[pdc_pkg::MODE_LSB +: pdc_pkg::MODE_W];
          pllsel_q <= pwdata[pdc_pkg::PLLSEL_BIT];
        end
        pdc_pkg::OFS_FIN: fin_q <= pwdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Frequency computation sequencer
  assign div.start    = ((st_q == pdc_pkg::PDC_IDLE) & pend_q)
                      | ((st_q == pdc_pkg::PDC_VCO) & div.done);
  assign div.dividend = prod;
  assign div.divisor  = (st_q == pdc_pkg::PDC_IDLE)
                      ? 9'(prescale_ratio) : n1n2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b1;
    end else if (cfg_wr) begin
      pend_q <= 1'b1;
    end else if (st_q == pdc_pkg::PDC_IDLE) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= pdc_pkg::PDC_IDLE;
      vco_q  <= 32'h00000000;
      pllo_q <= 32'h00000000;
    end else begin
      unique case (st_q)
        pdc_pkg::PDC_IDLE: if (pend_q) st_q <= pdc_pkg::PDC_VCO;
        pdc_pkg::PDC_VCO: if (div.done) begin
          vco_q <= sat32(div.quotient);
          st_q  <= pdc_pkg::PDC_OUT;
        end
        pdc_pkg::PDC_OUT: if (div.done) begin
          pllo_q <= sat32(div.quotient);
          st_q   <= pdc_pkg::PDC_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Oscillator and instruction frequency
  assign pll_mode = (mode_q == pdc_pkg::MODE_PLL_A)
                  | (mode_q == pdc_pkg::MODE_PLL_B);
  assign fosc_d   = (pll_mode & pllsel_q) ? pllo_q : fin_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fosc_q <= 32'h00000000;
      fcy_q  <= 32'h00000000;
    end else begin
      fosc_q <= fosc_d;
      fcy_q  <= fosc_d >> pdc_pkg::FCY_SHIFT;
    end
  end

  assign prdata                 = prdata_q;
  assign pready                 = pready_q;
  assign pslverr                = pslverr_q;
  assign doze_ratio_field       = doze_q;
  assign doze_active            = doze_enable_bit_q;
  assign pll_output_freq        = pllo_q;
  assign sys_osc_freq           = fosc_q;
  assign instruction_cycle_freq = fcy_q;

  // ==========================================================
  // Checks
  logic [CHK_W-1:0] q_lo;
  logic [CHK_W-1:0] q_hi;
  logic [CHK_W-1:0] p_ext;
  logic [8:0]       chk_div;

  assign chk_div = (st_q == pdc_pkg::PDC_VCO) ? 9'(prescale_ratio) : n1n2;
  assign q_lo    = CHK_W'(div.quotient) * CHK_W'(chk_div);
  assign q_hi    = q_lo + CHK_W'(chk_div);
  assign p_ext   = CHK_W'(prod);

  property p_fcy_half;
    @(posedge pclk) disable iff (!presetn)
      fcy_q == (fosc_q >> 1);
  endproperty
  a_fcy_half: assert property (p_fcy_half)
    else $error("instruction frequency is not half of oscillator");

  property p_fosc_pll;
    @(posedge pclk) disable iff (!presetn)
      (pll_mode && pllsel_q) |=> fosc_q == $past(pllo_q);
  endproperty
  a_fosc_pll: assert property (p_fosc_pll)
    else $error("oscillator frequency not taken from PLL output");

  property p_pll_exact;
    @(posedge pclk) disable iff (!presetn)
      (st_q == pdc_pkg::PDC_OUT && div.done && !pend_q)
        |-> (q_lo <= p_ext) && (p_ext < q_hi);
  endproperty
  a_pll_exact: assert property (p_pll_exact)
    else $error("PLL output quotient wrong");

  property p_ratio_div;
    @(posedge pclk) disable iff (!presetn)
      (st_q == pdc_pkg::PDC_VCO && div.done)
        |-> div.divisor == 9'((pre_q + 9'd2) * 9'd2 * (post_q + 9'd1));
  endproperty
  a_ratio_div: assert property (p_ratio_div)
    else $error("prescale or postscale ratio wrong");

  property p_vco_exact;
    @(posedge pclk) disable iff (!presetn)
      (st_q == pdc_pkg::PDC_VCO && div.done && !pend_q)
        |-> (q_lo <= p_ext) && (p_ext < q_hi);
  endproperty
  a_vco_exact: assert property (p_vco_exact)
    else $error("VCO quotient wrong");

  property p_doze_hold;
    @(posedge pclk) disable iff (!presetn)
      doze_enable_bit_q |=> $stable(doze_q);
  endproperty
  a_doze_hold: assert property (p_doze_hold)
    else $error("doze ratio changed while doze enabled");

  property p_doze_enable_bit_zero;
    @(posedge pclk) disable iff (!presetn)
      $rose(doze_enable_bit_q) |-> doze_q != 3'h0 ##1 (!doze_enable_bit_q || doze_q != 3'h0);
  endproperty
  a_doze_enable_bit_zero: assert property (p_doze_enable_bit_zero)
    else $error("doze enabled with zero ratio");

  property p_roi_clear;
    @(posedge pclk) disable iff (!presetn)
      (roi_q && irq_evt) |=> !doze_enable_bit_q;
  endproperty
  a_roi_clear: assert property (p_roi_clear)
    else $error("doze not cleared on interrupt");

endmodule : pdc_top

// ---- testbench/pll_divider_and_doze_control_tb_top.sv ----
module pll_divider_and_doze_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Stimulus and observation
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq_async;
  logic [2:0]  doze_ratio_field;
  logic        doze_active;
  logic [31:0] pll_output_freq;
  logic [31:0] sys_osc_freq;
  logic [31:0] instruction_cycle_freq;
  int          mismatches;
  int          checks_done;
  int          cycles;
  logic [31:0] rd;
  logic        err;

  pdc_top u_pdc_top (
    .pclk                   (pclk),
    .presetn                (presetn),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .irq_async              (irq_async),
    .doze_ratio_field       (doze_ratio_field),
    .doze_active            (doze_active),
    .pll_output_freq        (pll_output_freq),
    .sys_osc_freq           (sys_osc_freq),
    .instruction_cycle_freq (instruction_cycle_freq)
  );

  initial begin
    pclk = 1'b0;
  end
  always #20 pclk = ~pclk;

  // Two recomputes of about ninety cycles per loop pass dominate the run
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  // ==========================================================
  // Shared tasks and expectation functions
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // No wait-state count is assumed; the wait ends when pready is high, or at the timeout
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [31:0] sat(input logic [63:0] v);
    return (v > 64'h00000000FFFFFFFF) ? 32'hFFFFFFFF : v[31:0];
  endfunction : sat

  function automatic logic [31:0] clkdiv(input logic [4:0] pre,
      input logic [1:0] post, input logic recover_on_interrupt_bit, input logic en,
      input logic [2:0] ratio);
    return {14'h0000, post, 3'h0, pre, 3'h0, recover_on_interrupt_bit, en, ratio};
  endfunction : clkdiv

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, pdc_pkg::OFS_STAT, 32'h00000000);
      n++;
    end while (rd[1:0] !== 2'h0 && n < 300);
  endtask : wait_idle

  task automatic doze_step(input logic [31:0] w, input logic [2:0] e_ratio,
                           input logic e_en);
    apb(1'b1, pdc_pkg::OFS_CLKDIV, w);
    @(posedge pclk);
    chk("doze_ratio_field", {29'h0, doze_ratio_field}, {29'h0, e_ratio});
    chk("doze_active", {31'h0, doze_active}, {31'h0, e_en});
  endtask : doze_step

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] pll_input_freq;
    logic [4:0]  pre;
    logic [1:0]  post;
    logic [8:0]  mult;
    logic [63:0] prod;
    logic [31:0] e_vco;
    logic [31:0] e_pllo;
    logic [31:0] e_osc;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    irq_async = 1'b0;
    mismatches = 0;
    checks_done = 0;
    cycles = 0;
    void'($urandom(32'hD31724E5));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;

    apb(1'b0, pdc_pkg::OFS_CLKDIV, 32'h00000000);
    chk("clkdiv_reset", rd, 32'h00000000);
    apb(1'b0, 8'h40, 32'h00000000);
    chk("unmapped_err", {31'h0, err}, 32'h00000001);
    apb(1'b1, pdc_pkg::OFS_STAT, 32'hFFFFFFFF);
    chk("ro_err", {31'h0, err}, 32'h00000000);
    $display("test bus_basics done");

    // Every mode code with the PLL output both selected and not
    for (int i = 0; i < 16; i++) begin
      pll_input_freq  = $urandom() >> ($urandom() % 16);
      pre  = 5'($urandom());
      post = 2'($urandom());
      mult = 9'($urandom());
      if (i == 0) {pre, post, mult} = 16'h0000;
      if (i == 15) {pre, post, mult} = 16'hFFFF;
      apb(1'b1, pdc_pkg::OFS_FIN, pll_input_freq);
      apb(1'b1, pdc_pkg::OFS_MULT, {23'h0, mult});
      apb(1'b1, pdc_pkg::OFS_MODE, {28'h0, 4'(i)});
      apb(1'b1, pdc_pkg::OFS_CLKDIV, clkdiv(pre, post, 1'b0, 1'b0, 3'h0));
      wait_idle();
      prod   = 64'(pll_input_freq) * (64'(mult) + 64'h2);
      e_vco  = sat(prod / (64'(pre) + 64'h2));
      e_pllo = sat(prod / ((64'(pre) + 64'h2) * 64'h2 * (64'(post) + 64'h1)));
      e_osc  = ((i[2:0] == 3'h1 || i[2:0] == 3'h3) && i[3]) ? e_pllo : pll_input_freq;
      apb(1'b0, pdc_pkg::OFS_VCO, 32'h00000000);
      chk("vco", rd, e_vco);
      apb(1'b0, pdc_pkg::OFS_PLLO, 32'h00000000);
      chk("pllo_reg", rd, e_pllo);
      chk("pll_output_freq", pll_output_freq, e_pllo);
      chk("sys_osc_freq", sys_osc_freq, e_osc);
      apb(1'b0, pdc_pkg::OFS_FOSC, 32'h00000000);
      chk("fosc_reg", rd, e_osc);
      chk("instruction_cycle_freq", instruction_cycle_freq,
          e_osc >> 1);
      apb(1'b0, pdc_pkg::OFS_FCY, 32'h00000000);
      chk("fcy_reg", rd, e_osc >> 1);
    end
    $display("test pll_ratios done");

    doze_step(clkdiv(5'h00, 2'h0, 1'b0, 1'b1, 3'h0), 3'h0, 1'b0);
    doze_step(clkdiv(5'h00, 2'h0, 1'b0, 1'b1, 3'h5), 3'h5, 1'b1);
    doze_step(clkdiv(5'h00, 2'h0, 1'b0, 1'b1, 3'h2), 3'h5, 1'b1);
    doze_step(clkdiv(5'h00, 2'h0, 1'b0, 1'b0, 3'h0), 3'h5, 1'b0);
    doze_step(clkdiv(5'h00, 2'h0, 1'b0, 1'b0, 3'h0), 3'h0, 1'b0);
    doze_step(clkdiv(5'h00, 2'h0, 1'b0, 1'b1, 3'h0), 3'h0, 1'b0);
    $display("test doze_protect done");

    // Recover bit clear: interrupt must leave doze untouched; recover bit set: interrupt must clear doze enable
    doze_step(clkdiv(5'h00, 2'h0, 1'b0, 1'b1, 3'h7), 3'h7, 1'b1);
    @(posedge pclk);
    irq_async <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("doze_kept", {31'h0, doze_active}, 32'h00000001);
    irq_async <= 1'b0;
    doze_step(clkdiv(5'h00, 2'h0, 1'b1, 1'b1, 3'h3), 3'h7, 1'b1);
    repeat (4) @(posedge pclk);
    irq_async <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("doze_cleared", {31'h0, doze_active}, 32'h00000000);
    irq_async <= 1'b0;
    $display("test doze_recover done");
    close_out();
  end

endmodule : pll_divider_and_doze_control_tb_top
